// ==== inc/spc_pkg.sv ====
// Functional notes
// - Every serial command bus command is exactly 16 bits, sent with the fixed framing.
// - A command carries the target address first, then the opcode; data only afterwards.
// - Address zero is a broadcast to all modules; others address one module each.
// - Test port access sends the target instruction, all other chips get bypass.
// - A non-final data transfer leaves the target in Shift-DR for continuation.
// - A final data transfer shifts its bits, then returns to Run-Test/Idle.
// - First non-final instruction transfer enters Shift-IR; later ones stay there.
// - A final instruction transfer shifts its bits, then returns to Run-Test/Idle.
// - Exactly one port is connected before a transfer; fallback unless one is named.
// - Receive-only transfers shift a dummy whose length sets bits captured.
// - A raw caller 16-bit pattern can be sent without address or opcode.
// - Instruction register length is configurable per chip, 16 bits by default.
package spc_pkg;
    localparam int DATA_W     = 32;
    localparam int LEN_W      = 6;
    localparam int CNT_W      = 7;
    localparam int ADDR_W     = 8;
    localparam int OPC_W      = 8;
    localparam int NPORT      = 4;
    localparam int PORT_W     = 2;
    localparam int FIFO_DEPTH = 8;

    localparam logic [LEN_W-1:0]  CMD_LEN          = 6'h10;
    localparam logic [LEN_W-1:0]  IR_LEN_DEFAULT   = 6'h10;
    localparam logic [LEN_W-1:0]  MAX_LEN          = 6'h20;
    localparam logic [LEN_W-1:0]  MIN_LEN          = 6'h01;
    localparam logic [ADDR_W-1:0] BROADCAST_ADDR   = 8'h00;
    localparam logic [PORT_W-1:0] FALLBACK_PORT    = 2'h0;
    // Test clock is the link clock divided by four
    localparam logic [1:0]        PHASE_RISE       = 2'h2;
    localparam logic [1:0]        PHASE_LAST       = 2'h3;
    // Mode-select walks, first step in bit 0
    localparam logic [5:0]        TMS_IDLE_TO_DR   = 6'h01;
    localparam logic [2:0]        STEPS_IDLE_TO_DR = 3'h3;
    localparam logic [5:0]        TMS_IDLE_TO_IR   = 6'h03;
    localparam logic [2:0]        STEPS_IDLE_TO_IR = 3'h4;
    localparam logic [5:0]        TMS_EXIT_TO_DR   = 6'h07;
    localparam logic [2:0]        STEPS_EXIT_TO_DR = 3'h5;
    localparam logic [5:0]        TMS_EXIT_TO_IR   = 6'h0F;
    localparam logic [2:0]        STEPS_EXIT_TO_IR = 3'h6;
    localparam logic [1:0]        POST_STEPS       = 2'h2;

    typedef enum logic [1:0] {
        K_CMD = 2'b00,
        K_RAW = 2'b01,
        K_IR  = 2'b10,
        K_DR  = 2'b11
    } spc_kind_t;

    typedef enum logic [2:0] {
        L_IDLE  = 3'b000,
        L_PORT  = 3'b001,
        L_PRE   = 3'b010,
        L_SHIFT = 3'b011,
        L_POST  = 3'b100,
        L_DONE  = 3'b101
    } spc_lstate_t;

    typedef enum logic [1:0] {
        TAP_IDLE = 2'b00,
        TAP_SHDR = 2'b01,
        TAP_SHIR = 2'b10
    } spc_tap_t;

    typedef struct packed {
        logic              jtag;
        spc_kind_t         kind;
        logic              last;
        logic [PORT_W-1:0] port;
        logic [LEN_W-1:0]  len;
        logic [LEN_W-1:0]  pad;
        logic [DATA_W-1:0] data;
    } spc_xfer_t;
endpackage

// ==== inc/spc_fifo_if.sv ====
`timescale 1ns/100ps
interface spc_fifo_if #(parameter int WIDTH = 8);
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic             rd_valid;
    logic             rd_ready;
    logic [WIDTH-1:0] rd_data;

    modport store (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
    modport user  (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface

// ==== verilog/spc_fifo.sv ====
`timescale 1ns/100ps
module spc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic clk_sys_i,
    input  wire logic srst_i,
    spc_fifo_if.store port_if
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
        logic                        room;
        logic                        avail;
    } spc_fifo_state_t;

    spc_fifo_state_t st;
    spc_fifo_state_t next_st;
    logic            push;
    logic            pop;

    always_comb begin
        next_st = st;
        push    = port_if.wr_valid && st.room;
        pop     = port_if.rd_ready && st.avail;
        if (push) begin
            next_st.mem[st.wr_ptr] = port_if.wr_data;
            next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
        // Flags registered so ready and valid leave straight from flops
        next_st.room  = (next_st.count != (AW+1)'(DEPTH));
        next_st.avail = (next_st.count != '0);
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign port_if.wr_ready = st.room;
    assign port_if.rd_valid = st.avail;
    assign port_if.rd_data  = st.mem[st.rd_ptr];
endmodule // spc_fifo

// ==== verilog/spc_sequencer.sv ====
`timescale 1ns/100ps
module spc_sequencer import spc_pkg::*; (
    input  wire logic              clk_sys_i,
    input  wire logic              srst_i,
    input  wire logic              clk_link_i,
    input  wire logic              req_valid_i,
    output logic                   req_ready_o,
    input  wire logic              req_jtag_i,
    input  wire spc_kind_t         req_kind_i,
    input  wire logic              req_last_i,
    input  wire logic              req_port_sel_i,
    input  wire logic [PORT_W-1:0] req_port_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic [OPC_W-1:0]  req_opcode_i,
    input  wire logic [DATA_W-1:0] req_data_i,
    input  wire logic [LEN_W-1:0]  req_len_i,
    input  wire logic [LEN_W-1:0]  req_ir_len_i,
    input  wire logic [LEN_W-1:0]  req_bypass_i,
    output logic                   rsp_valid_o,
    output logic [DATA_W-1:0]      rsp_data_o,
    output logic                   scan_clk_o,
    output logic                   scan_mode_o,
    output logic                   scan_do_o,
    input  wire logic              scan_di_i,
    output logic [NPORT-1:0]       port_en_o
);
    typedef struct packed {
        logic              ack_m;
        logic              ack_s;
        logic              ack_seen;
        logic              req;
        logic              busy;
        spc_xfer_t         hold;
        logic              rsp_valid;
        logic [DATA_W-1:0] rsp_data;
    } spc_sys_t;

    typedef struct packed {
        logic              req_m;
        logic              req_s;
        logic              req_seen;
        logic              di_m;
        logic              di_s;
        logic              ack;
        logic [1:0]        phase;
        spc_lstate_t       st;
        spc_tap_t          tap;
        spc_xfer_t         xfer;
        logic [5:0]        pre_tms;
        logic [2:0]        pre_n;
        logic [CNT_W-1:0]  cnt;
        logic [LEN_W-1:0]  pad_left;
        logic [1:0]        post_n;
        logic [DATA_W-1:0] rx;
        logic [NPORT-1:0]  port_en;
        logic              sclk;
        logic              smode;
        logic              sdo;
    } spc_link_t;

    spc_sys_t         s;
    spc_sys_t         next_s;
    spc_link_t        l;
    spc_link_t        next_l;
    spc_xfer_t        wr_word;
    logic [LEN_W-1:0] len_c;
    logic [LEN_W-1:0] ir_len_c;
    logic             step;
    logic             active;
    spc_tap_t         want_tap;
    logic             rst_link_m;
    logic             rst_link;

    spc_fifo_if #(.WIDTH($bits(spc_xfer_t))) fif ();

    spc_fifo #(
        .WIDTH ($bits(spc_xfer_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .port_if   (fif.store)
    );

    // Request words are left-justified so every kind shifts out from the top bit
    always_comb begin
        len_c    = (req_len_i == '0) ? MIN_LEN : ((req_len_i > MAX_LEN) ? MAX_LEN : req_len_i);
        ir_len_c = (req_ir_len_i == '0) ? IR_LEN_DEFAULT :
                   ((req_ir_len_i > MAX_LEN) ? MAX_LEN : req_ir_len_i);
        wr_word      = '0;
        wr_word.kind = req_kind_i;
        wr_word.last = req_last_i;
        wr_word.port = req_port_sel_i ? req_port_i : FALLBACK_PORT;
        case (req_kind_i)
            K_CMD: begin
                wr_word.len  = CMD_LEN;
                wr_word.data = {req_addr_i, req_opcode_i, 16'h0000};
            end
            K_RAW: begin
                wr_word.len  = CMD_LEN;
                wr_word.data = {req_data_i[15:0], 16'h0000};
            end
            K_IR: begin
                wr_word.jtag = req_jtag_i;
                wr_word.len  = ir_len_c;
                wr_word.pad  = req_bypass_i;
                wr_word.data = req_data_i << (MAX_LEN - ir_len_c);
            end
            default: begin
                // Data bits double as the dummy of a receive-only transfer
                wr_word.jtag = req_jtag_i;
                wr_word.len  = len_c;
                wr_word.pad  = req_bypass_i;
                wr_word.data = req_data_i << (MAX_LEN - len_c);
            end
        endcase
    end

    assign fif.wr_valid = req_valid_i;
    assign fif.wr_data  = wr_word;
    assign fif.rd_ready = ~s.busy;

    // One word in flight: the hold word stays still until the link acknowledges
    always_comb begin
        next_s           = s;
        next_s.ack_m     = l.ack;
        next_s.ack_s     = s.ack_m;
        next_s.rsp_valid = 1'b0;
        if (fif.rd_valid && !s.busy) begin
            next_s.hold = fif.rd_data;
            next_s.req  = ~s.req;
            next_s.busy = 1'b1;
        end
        if (s.ack_s != s.ack_seen) begin
            next_s.ack_seen  = s.ack_s;
            next_s.busy      = 1'b0;
            next_s.rsp_valid = 1'b1;
            next_s.rsp_data  = l.rx;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    always_ff @(posedge clk_link_i) begin
        rst_link_m <= srst_i;
        rst_link   <= rst_link_m;
    end

    always_comb begin
        next_l       = l;
        next_l.req_m = s.req;
        next_l.req_s = l.req_m;
        next_l.di_m  = scan_di_i;
        next_l.di_s  = l.di_m;
        next_l.phase = l.phase + 2'h1;
        step         = (l.phase == PHASE_LAST);
        want_tap     = (l.st == L_IDLE) ? ((s.hold.kind == K_IR) ? TAP_SHIR : TAP_SHDR)
                                        : ((l.xfer.kind == K_IR) ? TAP_SHIR : TAP_SHDR);
        case (l.st)
            L_IDLE: begin
                if (l.req_s != l.req_seen) begin
                    next_l.req_seen = l.req_s;
                    next_l.xfer     = s.hold;
                    next_l.port_en  = '0;
                    next_l.port_en[s.hold.port] = 1'b1;
                    next_l.cnt      = CNT_W'(s.hold.len) + CNT_W'(s.hold.pad);
                    next_l.pad_left = s.hold.pad;
                    next_l.rx       = '0;
                    next_l.pre_n    = 3'h0;
                    next_l.pre_tms  = 6'h00;
                    // Already in the wanted shift state: continue without a walk
                    if (s.hold.jtag && l.tap != want_tap) begin
                        if (l.tap == TAP_IDLE) begin
                            next_l.pre_tms = (want_tap == TAP_SHIR) ? TMS_IDLE_TO_IR
                                                                    : TMS_IDLE_TO_DR;
                            next_l.pre_n   = (want_tap == TAP_SHIR) ? STEPS_IDLE_TO_IR
                                                                    : STEPS_IDLE_TO_DR;
                        end else begin
                            next_l.pre_tms = (want_tap == TAP_SHIR) ? TMS_EXIT_TO_IR
                                                                    : TMS_EXIT_TO_DR;
                            next_l.pre_n   = (want_tap == TAP_SHIR) ? STEPS_EXIT_TO_IR
                                                                    : STEPS_EXIT_TO_DR;
                        end
                    end
                    next_l.st = L_PORT;
                end
            end
            L_PORT: begin
                // Port connected first, held until the next phase-three step: one to four link clocks
                if (step) begin
                    next_l.st = (l.pre_n != 3'h0) ? L_PRE : L_SHIFT;
                end
            end
            L_PRE: begin
                if (step) begin
                    next_l.pre_tms = l.pre_tms >> 1;
                    next_l.pre_n   = l.pre_n - 3'h1;
                    if (l.pre_n == 3'h1) begin
                        next_l.st  = L_SHIFT;
                        next_l.tap = want_tap;
                    end
                end
            end
            L_SHIFT: begin
                if (step) begin
                    if (l.pad_left != '0) begin
                        next_l.pad_left = l.pad_left - 1'b1;
                    end else begin
                        next_l.rx        = {l.rx[DATA_W-2:0], l.di_s};
                        next_l.xfer.data = l.xfer.data << 1;
                    end
                    next_l.cnt = l.cnt - 1'b1;
                    if (l.cnt == CNT_W'(1)) begin
                        if (l.xfer.jtag && l.xfer.last) begin
                            next_l.st     = L_POST;
                            next_l.post_n = POST_STEPS;
                            next_l.tap    = TAP_IDLE;
                        end else begin
                            next_l.st = L_DONE;
                        end
                    end
                end
            end
            L_POST: begin
                if (step) begin
                    next_l.post_n = l.post_n - 2'h1;
                    if (l.post_n == 2'h1) begin
                        next_l.st = L_DONE;
                    end
                end
            end
            L_DONE: begin
                next_l.ack = ~l.ack;
                next_l.st  = L_IDLE;
            end
            default: begin
                next_l.st = L_IDLE;
            end
        endcase
        // Mode and data pins change only at the wrap to phase zero, the falling test clock edge
        active      = (next_l.st == L_PRE) || (next_l.st == L_SHIFT) || (next_l.st == L_POST);
        next_l.sclk = active && (next_l.phase >= PHASE_RISE);
        case (next_l.st)
            L_PRE:   next_l.smode = next_l.pre_tms[0];
            L_SHIFT: next_l.smode = next_l.xfer.jtag ?
                                    (next_l.xfer.last && next_l.cnt == CNT_W'(1)) : 1'b1;
            L_POST:  next_l.smode = (next_l.post_n == POST_STEPS);
            default: next_l.smode = 1'b0;
        endcase
        next_l.sdo = (next_l.st == L_SHIFT) &&
                     ((next_l.pad_left != '0) ? (next_l.xfer.kind == K_IR)
                                              : next_l.xfer.data[DATA_W-1]);
    end

    always_ff @(posedge clk_link_i) begin
        if (rst_link) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    assign req_ready_o = fif.wr_ready;
    assign rsp_valid_o = s.rsp_valid;
    assign rsp_data_o  = s.rsp_data;
    assign scan_clk_o  = l.sclk;
    assign scan_mode_o = l.smode;
    assign scan_do_o   = l.sdo;
    assign port_en_o   = l.port_en;

    chk_cmd_len_sixteen: assert property (@(posedge clk_link_i) disable iff (rst_link)
        $rose(l.st == L_SHIFT) && l.xfer.kind == K_CMD |-> l.cnt == CNT_W'(16))
        else $error("command shift length is not sixteen");

    chk_addr_before_opc: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        req_valid_i && req_ready_o && req_kind_i == K_CMD |->
            wr_word.data[31:16] == {req_addr_i, req_opcode_i} && wr_word.pad == '0)
        else $error("address and opcode misplaced in command");

    chk_broadcast_addr: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        req_valid_i && req_kind_i == K_CMD && req_addr_i == BROADCAST_ADDR |->
            wr_word.data[31:24] == BROADCAST_ADDR)
        else $error("broadcast address altered");

    chk_bypass_ones: assert property (@(posedge clk_link_i) disable iff (rst_link)
        l.st == L_SHIFT && l.pad_left != '0 && l.xfer.kind == K_IR |-> l.sdo)
        else $error("bypass instruction bit not one");

    chk_dr_stays_shift: assert property (@(posedge clk_link_i) disable iff (rst_link)
        l.st == L_DONE && l.xfer.jtag && !l.xfer.last && l.xfer.kind == K_DR |->
            l.tap == TAP_SHDR && !l.smode)
        else $error("non-final data transfer left Shift-DR");

    chk_dr_final_idle: assert property (@(posedge clk_link_i) disable iff (rst_link)
        $rose(l.st == L_POST) && l.xfer.kind == K_DR |->
            ##[7:9] (l.st == L_DONE && l.tap == TAP_IDLE && !l.smode))
        else $error("final data transfer did not reach idle");

    chk_ir_shift_entry: assert property (@(posedge clk_link_i) disable iff (rst_link)
        l.st == L_SHIFT && l.xfer.jtag && l.xfer.kind == K_IR |-> l.tap == TAP_SHIR)
        else $error("instruction shifted outside Shift-IR");

    chk_ir_final_idle: assert property (@(posedge clk_link_i) disable iff (rst_link)
        $rose(l.st == L_POST) && l.xfer.kind == K_IR |->
            l.smode ##4 !l.smode ##[3:5] l.st == L_DONE)
        else $error("final instruction transfer walk wrong");

    chk_one_port_on: assert property (@(posedge clk_link_i) disable iff (rst_link)
        l.st != L_IDLE |-> $onehot(l.port_en) && l.port_en[l.xfer.port])
        else $error("not exactly the selected port enabled");

    chk_rx_capture: assert property (@(posedge clk_link_i) disable iff (rst_link)
        l.st == L_SHIFT && l.phase == PHASE_LAST && l.pad_left == '0 |=>
            l.rx[0] == $past(l.di_s))
        else $error("target output bit not captured");

    chk_raw_pattern: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        req_valid_i && req_kind_i == K_RAW |->
            wr_word.data[31:16] == req_data_i[15:0] && wr_word.len == CMD_LEN)
        else $error("raw pattern altered");

    chk_ir_len_default: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        req_valid_i && req_kind_i == K_IR && req_ir_len_i == '0 |-> wr_word.len == 6'h10)
        else $error("default instruction length not sixteen");

    // End of a frame drops the mode line while the clock stops for good
    chk_mode_one_step: assert property (@(posedge clk_link_i) disable iff (rst_link)
        $changed(l.smode) && l.st != L_DONE |-> l.phase == 2'h0 && !l.sclk ##2 l.sclk)
        else $error("mode select changed off the falling edge");
endmodule // spc_sequencer

// ==== sim/spc_chip_model.sv ====
`timescale 1ns/100ps
module spc_chip_model #(
    parameter logic [31:0] REPLY = 32'hC3A55A3C
) (
    input  wire logic        srst_i,
    input  wire logic        clr_i,
    input  wire logic        jtag_i,
    input  wire logic        scan_clk_i,
    input  wire logic        scan_mode_i,
    input  wire logic        scan_do_i,
    output logic             scan_di_o,
    output logic [31:0]      cap_o,
    output logic [6:0]       cnt_o,
    output logic [3:0]       tap_o
);
    // Nibble i holds the successor of state i for mode-select 0 and 1
    localparam logic [63:0] NXT0 = 64'h1BDDBBA146644311;
    localparam logic [63:0] NXT1 = 64'h2FEFCC0287855920;
    logic [31:0] out_sr;
    logic        shifting;

    assign shifting = jtag_i ? (tap_o == 4'h4 || tap_o == 4'hB) : scan_mode_i;

    // No address decode, so broadcast and own address both land here
    always @(posedge scan_clk_i or posedge srst_i or posedge clr_i) begin
        if (srst_i || clr_i) begin
            cap_o <= 32'h0;
            cnt_o <= 7'h0;
            if (srst_i) tap_o <= 4'h1;
        end else begin
            if (shifting) begin
                cap_o <= {cap_o[30:0], scan_do_i};
                cnt_o <= cnt_o + 7'h1;
            end
            if (jtag_i) begin
                tap_o  <= scan_mode_i ? NXT1[tap_o*4 +: 4] : NXT0[tap_o*4 +: 4];
                out_sr <= (tap_o == 4'h3) ? REPLY : (tap_o == 4'h4) ? out_sr << 1 : out_sr;
            end
        end
    end

    // Outside a data shift the line toggles, so a stale bit never looks valid
    always @(negedge scan_clk_i or posedge srst_i) begin
        if (srst_i) scan_di_o <= 1'b0;
        else scan_di_o <= (jtag_i && tap_o == 4'h4) ? out_sr[31] : ~scan_di_o;
    end
endmodule // spc_chip_model

// ==== sim/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    import spc_pkg::*;
    typedef struct {
        spc_kind_t         kind;
        logic              jtag, last, psel;
        logic [PORT_W-1:0] port;
        logic [7:0]        addr, opc;
        logic [LEN_W-1:0]  len, irl, byp;
        logic [31:0]       data, ecap, ersp;
        logic [6:0]        ecnt;
        logic [3:0]        etap, eport;
        logic              crsp;
    } spc_row_t;
    logic clk_sys = 1'b0, clk_link = 1'b0, srst = 1'b0, clr = 1'b0, mjtag = 1'b0;
    logic req_valid = 1'b0, req_jtag = 1'b0, req_last = 1'b0, req_psel = 1'b0;
    spc_kind_t         req_kind = K_CMD;
    logic [PORT_W-1:0] req_port = '0;
    logic [7:0]        req_addr = '0, req_opc = '0;
    logic [31:0]       req_data = '0;
    logic [LEN_W-1:0]  req_len = '0, req_irl = '0, req_byp = '0;
    logic              req_ready, rsp_valid, scan_clk, scan_mode, scan_do, scan_di, rdy, refused;
    logic [31:0]       rsp_data, last_rsp, cap;
    logic [NPORT-1:0]  port_en;
    logic [6:0]        cnt;
    logic [3:0]        tap;
    int                fail_count = 0, total_checks = 0, rsp_cnt = 0, i, n, acc;
    spc_row_t          rows[10];

    initial forever #50 clk_sys = ~clk_sys;
    initial begin
        #3.7;
        forever #7.5 clk_link = ~clk_link;
    end

    spc_sequencer uut (.clk_sys_i(clk_sys), .srst_i(srst), .clk_link_i(clk_link),
        .req_valid_i(req_valid), .req_ready_o(req_ready), .req_jtag_i(req_jtag),
        .req_kind_i(req_kind), .req_last_i(req_last), .req_port_sel_i(req_psel),
        .req_port_i(req_port), .req_addr_i(req_addr), .req_opcode_i(req_opc),
        .req_data_i(req_data), .req_len_i(req_len), .req_ir_len_i(req_irl),
        .req_bypass_i(req_byp), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
        .scan_clk_o(scan_clk), .scan_mode_o(scan_mode), .scan_do_o(scan_do),
        .scan_di_i(scan_di), .port_en_o(port_en));

    spc_chip_model chip (.srst_i(srst), .clr_i(clr), .jtag_i(mjtag), .scan_clk_i(scan_clk),
        .scan_mode_i(scan_mode), .scan_do_i(scan_do), .scan_di_o(scan_di), .cap_o(cap),
        .cnt_o(cnt), .tap_o(tap));

    always @(posedge clk_sys) if (rsp_valid) begin
        rsp_cnt++;
        last_rsp = rsp_data;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic drive(input spc_row_t r);
        {req_jtag, req_last, req_psel, req_port} = {r.jtag, r.last, r.psel, r.port};
        {req_addr, req_opc, req_data} = {r.addr, r.opc, r.data};
        {req_len, req_irl, req_byp} = {r.len, r.irl, r.byp};
        req_kind = r.kind;
        mjtag = r.jtag && (r.kind inside {K_IR, K_DR});
    endtask

    task automatic wait_rsp(input int k);
        repeat (2000) begin
            if (rsp_cnt >= k) break;
            @(posedge clk_sys);
        end
        chk(32'(rsp_cnt >= k), 32'h1, "answer count");
    endtask

    task automatic run_row(input spc_row_t r);
        n = rsp_cnt;
        clr = 1'b1;
        #1 clr = 1'b0;
        @(posedge clk_sys);
        #5;
        drive(r);
        req_valid = 1'b1;
        do begin
            @(negedge clk_sys);
            rdy = req_ready;
            @(posedge clk_sys);
        end while (!rdy);
        #5 req_valid = 1'b0;
        wait_rsp(n + 1);
        chk(cap, r.ecap, "shifted bits");
        chk(32'(cnt), 32'(r.ecnt), "bit count");
        chk(32'(tap), 32'(r.etap), "test port state");
        chk(32'(port_en), 32'(r.eport), "port enable");
        chk(32'(scan_clk), 32'h0, "clock idle level");
        if (r.crsp) chk(last_rsp, r.ersp, "captured reply");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #1_000_000;
        fail_count++;
        tally_and_finish;
    end

    initial begin
        // Raised after time zero so the partner model sees a real reset edge
        #1 srst = 1'b1;
        rows[0] = '{K_CMD, 0, 0, 0, 2'h0, 8'h00, 8'h5A, 0, 0, 0, 0, 32'h005A, 0, 7'h10, 4'h1, 4'h1, 0};
        rows[1] = '{K_CMD, 1, 0, 1, 2'h2, 8'h13, 8'hC4, 0, 0, 0, 0, 32'h13C4, 0, 7'h10, 4'h1, 4'h4, 0};
        rows[2] = '{K_RAW, 0, 0, 1, 2'h3, 0, 0, 0, 0, 0, 32'hBEEF, 32'hBEEF, 0, 7'h10, 4'h1, 4'h8, 0};
        rows[3] = '{K_IR, 1, 0, 0, 0, 0, 0, 0, 0, 6'h02, 32'h1234, 32'h31234, 0, 7'h12, 4'hB, 4'h1, 0};
        rows[4] = '{K_IR, 1, 0, 0, 0, 0, 0, 0, 6'h08, 0, 32'hA5, 32'hA5, 0, 7'h08, 4'hB, 4'h1, 0};
        rows[5] = '{K_IR, 1, 1, 0, 0, 0, 0, 0, 6'h04, 0, 32'h9, 32'h9, 0, 7'h04, 4'h1, 4'h1, 0};
        rows[6] = '{K_DR, 1, 0, 0, 0, 0, 0, 6'h08, 0, 6'h03, 32'h3C, 32'h3C, 32'h1D, 7'h0B, 4'h4, 4'h1, 1};
        rows[7] = '{K_DR, 1, 1, 0, 0, 0, 0, 6'h05, 0, 0, 32'h15, 32'h15, 32'h05, 7'h05, 4'h1, 4'h1, 1};
        rows[8] = '{K_DR, 1, 1, 0, 0, 0, 0, 6'h00, 0, 0, 32'h0, 32'h0, 32'h1, 7'h01, 4'h1, 4'h1, 1};
        rows[9] = '{K_DR, 1, 1, 0, 0, 0, 0, 6'h20, 0, 0, 32'hF0E1D2C3, 32'hF0E1D2C3, 32'hC3A55A3C,
                    7'h20, 4'h1, 4'h1, 1};
        repeat (12) @(posedge clk_sys);
        #5 srst = 1'b0;
        repeat (5) @(posedge clk_sys);
        #5;
        chk(32'(port_en), 32'h0, "port enable after reset");
        chk(32'(req_ready), 32'h1, "ready after reset");
        for (i = 0; i < 10; i++) run_row(rows[i]);
        // Stream commands for ten cycles so the buffer refuses some, then drain it all
        n = rsp_cnt;
        acc = 0;
        refused = 1'b0;
        #5;
        drive(rows[0]);
        req_valid = 1'b1;
        repeat (10) begin
            @(negedge clk_sys);
            rdy = req_ready;
            @(posedge clk_sys);
            if (rdy) acc++;
            else refused = 1'b1;
        end
        #5 req_valid = 1'b0;
        chk(32'(refused), 32'h1, "buffer pushback");
        wait_rsp(n + acc);
        repeat (50) @(posedge clk_sys);
        chk(32'(rsp_cnt), 32'(n + acc), "answers after drain");
        // Reset in mid-shift must abandon the transfer cleanly
        #5;
        drive(rows[9]);
        req_valid = 1'b1;
        @(posedge clk_sys);
        #5 req_valid = 1'b0;
        repeat (20) @(posedge clk_sys);
        #5 srst = 1'b1;
        repeat (12) @(posedge clk_sys);
        #5;
        chk(32'({port_en, scan_clk, scan_mode}), 32'h0, "pins in reset");
        srst = 1'b0;
        repeat (10) @(posedge clk_sys);
        run_row(rows[6]);
        // Walking out of Shift-DR clocks one extra bit into the data register
        rows[5].ecnt = 7'h05;
        run_row(rows[5]);
        tally_and_finish;
    end
endmodule // tb_top
